// ==== mpo_regs.svh ====
// Register offsets, reset values and timing constants of the monitor pulse output.
`ifndef MPO_REGS_SVH
`define MPO_REGS_SVH

// Register byte offsets.
`define MPO_OFS_SPEED_REF    8'h00
`define MPO_OFS_CURRENT_REF  8'h04
`define MPO_OFS_SOURCE_SEL   8'h08
`define MPO_OFS_GAIN_TRIM    8'h0C
`define MPO_OFS_WRITE_PROT   8'h10
`define MPO_OFS_STATUS       8'h14
`define MPO_OFS_INCREMENT    8'h18

// Reset values.
`define MPO_RST_SPEED_REF    16'd3000
`define MPO_RST_SOURCE_SEL   8'd1
`define MPO_RST_GAIN_TRIM    16'h0400
`define MPO_RST_WRITE_PROT   8'h00

// Setting limits; current is held in units of 0.01 A.
`define MPO_SPEED_MAX_SMALL  16'd12000
`define MPO_SPEED_MAX_LARGE  16'd8000
`define MPO_CURRENT_MAX      16'd50000

// Monitor source codes.
`define MPO_SRC_SPEED        8'd1
`define MPO_SRC_CURRENT      8'd2
`define MPO_SRC_REFERENCE    8'd21

// Write protect value that allows any write while running.
`define MPO_PROT_ALWAYS      8'd2

// Gain trim unity value is one shifted left by this many bits.
`define MPO_TRIM_SHIFT       10

// Status field positions.
`define MPO_STAT_CLAMP       0
`define MPO_STAT_BUSY        1
`define MPO_STAT_RUNNING     2
`define MPO_STAT_LARGE       3
`define MPO_STAT_REFUSED     4

// Pulse rates and clock.
`define MPO_CLK_HZ           64'd25000000
`define MPO_FS_PPS           64'd1440
`define MPO_MAX_PPS          64'd2400
`define MPO_ACC_BITS         32
`define MPO_FS_INC           ((`MPO_FS_PPS << `MPO_ACC_BITS) / `MPO_CLK_HZ)
`define MPO_MAX_INC          ((`MPO_MAX_PPS << `MPO_ACC_BITS) / `MPO_CLK_HZ)

// Divider widths.
`define MPO_NUM_BITS         50
`define MPO_DEN_BITS         26

`endif

// ==== mpo_pkg.sv ====
// Types shared by the monitor pulse output files.
package mpo_pkg;

	typedef logic [31:0] mpo_word_t;

	typedef enum {
		MPO_CALC_IDLE,
		MPO_CALC_WAIT
	} mpo_calc_state_t;

endpackage

// ==== mpo_divider.sv ====
// Restoring divider that yields one quotient bit per clock.
`timescale 1ns/1ps
`include "mpo_regs.svh"

module mpo_divider (
	// Clock and reset.
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// Request.
	input  wire logic                      start,
	input  wire logic [`MPO_NUM_BITS-1:0]  numer,
	input  wire logic [`MPO_DEN_BITS-1:0]  denom,
	// Result.
	output logic                           busy,
	output logic                           done,
	output logic      [`MPO_NUM_BITS-1:0]  quot
);
	import mpo_pkg::*;

	logic [`MPO_NUM_BITS-1:0] work;
	logic [`MPO_DEN_BITS-1:0] den;
	logic [`MPO_DEN_BITS:0]   rem;
	logic [6:0]               count;

	wire logic [`MPO_DEN_BITS:0] shifted = {rem[`MPO_DEN_BITS-1:0], work[`MPO_NUM_BITS-1]};
	wire logic                   fits    = shifted >= {1'b0, den};
	wire logic [`MPO_DEN_BITS:0] next_rem = fits ? shifted - {1'b0, den} : shifted;
	wire logic                   last    = count == 7'(`MPO_NUM_BITS - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			work  <= '0;
			den   <= '0;
			rem   <= '0;
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
			quot  <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				work  <= numer;
				den   <= denom;
				rem   <= '0;
				count <= '0;
				busy  <= 1'b1;
			end else if (busy) begin
				rem   <= next_rem;
				work  <= {work[`MPO_NUM_BITS-2:0], fits};
				count <= count + 7'h01;
				if (last) begin
					busy <= 1'b0;
					done <= 1'b1;
					quot <= {work[`MPO_NUM_BITS-2:0], fits};
				end
			end
		end
	end

endmodule

// ==== mpo_pulse_monitor.sv ====
// Monitor pulse train generator with its AHB-Lite register slave.
//
// Summary of operation
// - The monitored quantity is chosen by the source selection and full scale gives 1440 pulses/s.
// - With speed monitored, the speed full-scale reference is the speed giving 1440 pulses/s, 3000 r/min at reset.
// - The pulse rate is linear in the monitored speed relative to the speed full-scale reference.
// - The pulse rate never exceeds 2400 pulses/s whatever the value or reference.
// - With current monitored, the current reference (0 to 500 A) gives 1440 pulses/s, rated current at reset.
// - The pulse rate is linear in the monitored current relative to the current full-scale reference.
// - Source selection 21 gives a constant 1440 pulses/s for calibration.
// - The speed reference accepts up to 12000 r/min on small units and up to 8000 r/min on the large unit.
// - Both full-scale references stay writable while running even with write protect at 0.
// - Gain trim changes are accepted while running and applied to the output scaling.
`timescale 1ns/1ps
`include "mpo_regs.svh"

module mpo_pulse_monitor #(
	parameter logic [15:0] RATED_CURRENT = 16'd500
) (
	// Clock and reset.
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave.
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire mpo_pkg::mpo_word_t hwdata,
	input  wire logic              hready,
	output mpo_pkg::mpo_word_t     hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Monitored quantities from the drive core, current in 0.01 A.
	input  wire logic [15:0]       speed_value,
	input  wire logic [15:0]       current_value,
	input  wire logic              motor_running,
	// Unit size strap pin, high on the large unit.
	input  wire logic              large_unit_pin,
	// Meter pins.
	output logic                   pulse_monitor_output,
	output logic                   monitor_common_return
);
	import mpo_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Strap synchroniser.
	// The strap comes from outside the clock domain, so two flops guard the limit logic.

	logic large_meta;
	logic large_sync;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			large_meta <= 1'b0;
			large_sync <= 1'b0;
		end else begin
			large_meta <= large_unit_pin;
			large_sync <= large_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus address phase capture.

	logic [15:0]       speed_fullscale_ref;
	logic [15:0]       current_fullscale_ref;
	logic [7:0]        monitor_source_select;
	logic [15:0]       meter_gain_trim;
	logic [7:0]        param_write_protect;
	logic              clamp_active;
	logic              write_refused;
	logic [31:0]       phase_inc;
	logic              wr_pend;
	logic [7:0]        wr_addr;

	wire logic req_valid = hsel && hready && htrans[1];
	wire logic req_write = req_valid && hwrite;
	wire logic req_read  = req_valid && !hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_pend <= 1'b0;
		else
			wr_pend <= req_write;
	end

	// The write address moves only for taken writes, so idle bus cycles leave it still.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_addr <= 8'h00;
		else if (req_write)
			wr_addr <= haddr;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Register writes.

	// Offsets are compared in full, so the map does not repeat higher up.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = addr == ofs;
	endfunction

	wire logic [15:0] speed_max   = large_sync ? `MPO_SPEED_MAX_LARGE : `MPO_SPEED_MAX_SMALL;
	wire logic [15:0] wr_half     = hwdata[15:0];
	wire logic [15:0] speed_wr    = (wr_half > speed_max) ? speed_max : wr_half;
	wire logic [15:0] current_wr  = (wr_half > `MPO_CURRENT_MAX) ? `MPO_CURRENT_MAX : wr_half;
	wire logic        src_allowed = !motor_running || param_write_protect == `MPO_PROT_ALWAYS;
	wire logic        wr_speed    = wr_pend && hit(wr_addr, `MPO_OFS_SPEED_REF);
	wire logic        wr_current  = wr_pend && hit(wr_addr, `MPO_OFS_CURRENT_REF);
	wire logic        wr_source   = wr_pend && hit(wr_addr, `MPO_OFS_SOURCE_SEL);
	wire logic        wr_trim     = wr_pend && hit(wr_addr, `MPO_OFS_GAIN_TRIM);
	wire logic        wr_prot     = wr_pend && hit(wr_addr, `MPO_OFS_WRITE_PROT);
	wire logic        wr_status   = wr_pend && hit(wr_addr, `MPO_OFS_STATUS);

	// The references and the trim ignore write protect and the running state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			speed_fullscale_ref <= `MPO_RST_SPEED_REF;
		else if (wr_speed)
			speed_fullscale_ref <= speed_wr;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			current_fullscale_ref <= RATED_CURRENT;
		else if (wr_current)
			current_fullscale_ref <= current_wr;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			meter_gain_trim <= `MPO_RST_GAIN_TRIM;
		else if (wr_trim)
			meter_gain_trim <= wr_half;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			monitor_source_select <= `MPO_RST_SOURCE_SEL;
		else if (wr_source && src_allowed)
			monitor_source_select <= hwdata[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			param_write_protect <= `MPO_RST_WRITE_PROT;
		else if (wr_prot)
			param_write_protect <= hwdata[7:0];
	end

	// Refused source writes leave a sticky flag; a new refusal wins over the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			write_refused <= 1'b0;
		else if (wr_source && !src_allowed)
			write_refused <= 1'b1;
		else if (wr_status && hwdata[`MPO_STAT_REFUSED])
			write_refused <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads.

	logic div_busy;

	logic [31:0] status_word;

	always_comb begin
		status_word                    = 32'h0;
		status_word[`MPO_STAT_CLAMP]   = clamp_active;
		status_word[`MPO_STAT_BUSY]    = div_busy;
		status_word[`MPO_STAT_RUNNING] = motor_running;
		status_word[`MPO_STAT_LARGE]   = large_sync;
		status_word[`MPO_STAT_REFUSED] = write_refused;
	end

	wire logic [31:0] read_mux =
		hit(haddr, `MPO_OFS_SPEED_REF)   ? {16'h0, speed_fullscale_ref} :
		hit(haddr, `MPO_OFS_CURRENT_REF) ? {16'h0, current_fullscale_ref} :
		hit(haddr, `MPO_OFS_SOURCE_SEL)  ? {24'h0, monitor_source_select} :
		hit(haddr, `MPO_OFS_GAIN_TRIM)   ? {16'h0, meter_gain_trim} :
		hit(haddr, `MPO_OFS_WRITE_PROT)  ? {24'h0, param_write_protect} :
		hit(haddr, `MPO_OFS_STATUS)      ? status_word :
		hit(haddr, `MPO_OFS_INCREMENT)   ? phase_inc : 32'h0;

	// Read data is loaded in the address phase so that it stands through the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (req_read)
			hrdata <= read_mux;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Increment computation.

	mpo_calc_state_t calc_state;
	mpo_calc_state_t next_calc_state;
	logic            div_done;
	logic [`MPO_NUM_BITS-1:0] div_quot;

	wire logic        src_speed   = monitor_source_select == `MPO_SRC_SPEED;
	wire logic        src_current = monitor_source_select == `MPO_SRC_CURRENT;
	wire logic        src_ref     = monitor_source_select == `MPO_SRC_REFERENCE;
	wire logic [15:0] mon_value   = src_speed ? speed_value : current_value;
	wire logic [15:0] mon_ref     = src_speed ? speed_fullscale_ref : current_fullscale_ref;
	wire logic [33:0] fs_scaled   = 34'(mon_value) * 34'(`MPO_FS_INC);
	wire logic [`MPO_NUM_BITS-1:0] numer = `MPO_NUM_BITS'(fs_scaled) *
		`MPO_NUM_BITS'(meter_gain_trim);
	wire logic [`MPO_DEN_BITS-1:0] denom = `MPO_DEN_BITS'(mon_ref) << `MPO_TRIM_SHIFT;
	wire logic        div_start   = calc_state == MPO_CALC_IDLE;
	wire logic        over_max    = div_quot > `MPO_NUM_BITS'(`MPO_MAX_INC);
	wire logic [31:0] div_inc     = over_max ? 32'(`MPO_MAX_INC) : div_quot[31:0];

	// One division takes fifty clocks, so a change reaches the output within two divisions.
	mpo_divider i_mpo_divider (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (div_start),
		.numer   (numer),
		.denom   (denom),
		.busy    (div_busy),
		.done    (div_done),
		.quot    (div_quot)
	);

	// The divider restarts right after each result, so the increment tracks the value.
	always_comb begin
		case (calc_state)
			MPO_CALC_IDLE: next_calc_state = MPO_CALC_WAIT;
			MPO_CALC_WAIT: next_calc_state = div_done ? MPO_CALC_IDLE : MPO_CALC_WAIT;
			default:       next_calc_state = MPO_CALC_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			calc_state <= MPO_CALC_IDLE;
		else
			calc_state <= next_calc_state;
	end

	// A settings write that lands while a division runs makes its result stale; the result is
	// dropped, so only a division started after the write sets the rate, unless the write lands in the cycle a result is taken.
	logic calc_stale;

	wire logic set_write = wr_speed || wr_current || wr_trim || (wr_source && src_allowed);
	wire logic use_quot  = div_done && !calc_stale;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			calc_stale <= 1'b0;
		else if (set_write)
			calc_stale <= 1'b1;
		else if (div_start)
			calc_stale <= 1'b0;
	end

	// The reference source bypasses the divider; unknown sources stay silent.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_inc    <= 32'h0;
			clamp_active <= 1'b0;
		end else if (src_ref) begin
			phase_inc    <= 32'(`MPO_FS_INC);
			clamp_active <= 1'b0;
		end else if (!(src_speed || src_current)) begin
			phase_inc    <= 32'h0;
			clamp_active <= 1'b0;
		end else if (use_quot) begin
			phase_inc    <= div_inc;
			clamp_active <= over_max;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase accumulator; its top bit is the square-wave pulse train.

	logic [`MPO_ACC_BITS-1:0] phase_acc;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			phase_acc <= '0;
		else
			phase_acc <= phase_acc + phase_inc;
	end

	// The pin is driven from a flop so that adder glitches never reach the meter.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pulse_monitor_output <= 1'b0;
		else
			pulse_monitor_output <= phase_acc[`MPO_ACC_BITS-1];
	end

	// The return pin is the meter's reference level and is held low.
	assign monitor_common_return = 1'b0;

endmodule

// ==== mpo_pulse_monitor_assertions.sv ====
// Port checker of the monitor pulse output.
`timescale 1ns/1ps
module mpo_pulse_monitor_checker (
	// Clock and reset.
	input wire logic               hclk,
	input wire logic               hresetn,
	// Bus.
	input wire logic               hsel,
	input wire logic [7:0]         haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic               hready,
	input wire mpo_pkg::mpo_word_t hrdata,
	input wire logic               hreadyout,
	input wire logic               hresp,
	// Meter pins.
	input wire logic               pulse_monitor_output,
	input wire logic               monitor_common_return
);
	import mpo_pkg::*;
	logic        rd;
	logic        last_p;
	logic [15:0] gap;
	// A read address phase is taken at this edge.
	assign rd = hsel && hready && htrans[1] && !hwrite;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_p <= 1'b0;
			gap    <= 16'h0000;
		end else begin
			last_p <= pulse_monitor_output;
			gap    <= (pulse_monitor_output != last_p) ? 16'h0001 : gap + {15'h0000, ~&gap};
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_RETURN_LOW: assert property (monitor_common_return == 1'b0)
		else $error("common return not low");
	AST_HALF_PERIOD: assert property ((pulse_monitor_output != last_p) |-> gap >= 16'h1450)
		else $error("pulse half period too short");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	AST_RDATA_HOLD: assert property (!rd |=> $stable(hrdata))
		else $error("read data changed without a read");
	AST_SPEED_MAX: assert property (rd && haddr == 8'h00 |=> hrdata <= 32'h00002EE0)
		else $error("speed reference above limit");
	AST_SPEED_UPPER: assert property (rd && haddr == 8'h00 |=> hrdata[31:16] == 16'h0000)
		else $error("speed reference upper bits set");
	AST_CUR_MAX: assert property (rd && haddr == 8'h04 |=> hrdata <= 32'h0000C350)
		else $error("current reference above limit");
	AST_INC_MAX: assert property (rd && haddr == 8'h18 |=> hrdata <= 32'h00064A9C)
		else $error("increment above clamp");
	AST_OUT_RESET: assert property ($rose(hresetn) |-> !pulse_monitor_output)
		else $error("pulse high after reset");
endmodule

// ==== mpo_meter_model.sv ====
// Pulse counter model that times the monitor pulse train.
`timescale 1ns/1ps
module mpo_meter_model (
	// Clock and reset.
	input wire logic    hclk,
	input wire logic    hresetn,
	// Meter pins.
	input wire logic    pulse_monitor_output,
	input wire logic    monitor_common_return,
	// Measurement.
	output int unsigned period,
	output int unsigned edges
);
	int unsigned run;
	logic        prev;
	// A pulse is counted when the output rises above the common return.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run    <= 0;
			prev   <= 1'b0;
			period <= 0;
			edges  <= 0;
		end else begin
			prev <= pulse_monitor_output;
			run  <= run + 1;
			if (pulse_monitor_output && !prev && !monitor_common_return) begin
				period <= run + 1;
				edges  <= edges + 1;
				run    <= 0;
			end
		end
	end
endmodule

// ==== tb_mpo_pulse_monitor.sv ====
// Testbench of the monitor pulse output.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tb_mpo_pulse_monitor;
	import mpo_pkg::*;
	localparam logic [15:0] RC = 16'h07D0;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        motor_running, large_unit_pin, pulse_monitor_output, monitor_common_return;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] speed_value, current_value;
	mpo_word_t   hwdata, hrdata, rd;
	int          mismatches, samples_checked;
	int unsigned period, edges;
	mpo_pulse_monitor #(.RATED_CURRENT(RC)) i_mpo_pulse_monitor (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .speed_value, .current_value, .motor_running, .large_unit_pin,
		.pulse_monitor_output, .monitor_common_return);
	mpo_meter_model i_mpo_meter_model (.hclk, .hresetn, .pulse_monitor_output,
		.monitor_common_return, .period, .edges);
	always #20 hclk = ~hclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				mismatches++;
				tally_and_finish();
			end
			@(posedge hclk);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input mpo_word_t d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input mpo_word_t e);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic inc_chk(input mpo_word_t e);
		for (int i = 0; i < 80; i++) begin
			xfer(1'b0, 8'h18, 32'h0);
			if (rd === e) break;
		end
		`CHK(rd, e)
	endtask
	task automatic period_chk(input int unsigned lo, input int unsigned hi);
		int unsigned e0;
		int          n;
		e0 = edges;
		n = 0;
		while (edges < e0 + 2) begin
			@(posedge hclk);
			n++;
			if (n > 40000) begin
				mismatches++;
				tally_and_finish();
			end
		end
		`CHK(period >= lo && period <= hi, 1'b1)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk(8'h00, 32'h00000BB8);
		rd_chk(8'h04, {16'h0, RC});
		rd_chk(8'h08, 32'h00000001);
		rd_chk(8'h0C, 32'h00000400);
		rd_chk(8'h10, 32'h00000000);
		rd_chk(8'h1C, 32'h00000000);
		$display("reset values done");
	endtask
	task automatic t_speed();
		speed_value <= 16'h0BB8;
		inc_chk(32'h0003C65E);
		speed_value <= 16'h05DC;
		inc_chk(32'h0001E32F);
		speed_value <= 16'h1770;
		inc_chk(32'h00064A9C);
		$display("speed scaling done");
	endtask
	task automatic t_current();
		xfer(1'b1, 8'h08, 32'h2);
		xfer(1'b1, 8'h04, 32'hC350);
		current_value <= 16'h61A8;
		inc_chk(32'h0001E32F);
		current_value <= 16'hC350;
		inc_chk(32'h0003C65E);
		xfer(1'b1, 8'h04, 32'hEA60);
		rd_chk(8'h04, 32'h0000C350);
		$display("current scaling done");
	endtask
	task automatic t_running();
		xfer(1'b1, 8'h08, 32'h1);
		motor_running <= 1'b1;
		speed_value   <= 16'h0BB8;
		xfer(1'b1, 8'h00, 32'h1770);
		rd_chk(8'h00, 32'h00001770);
		xfer(1'b1, 8'h04, 32'h61A8);
		rd_chk(8'h04, 32'h000061A8);
		inc_chk(32'h0001E32F);
		xfer(1'b1, 8'h0C, 32'h800);
		inc_chk(32'h0003C65E);
		xfer(1'b1, 8'h08, 32'h2);
		rd_chk(8'h08, 32'h00000001);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(rd[4], 1'b1)
		`CHK(rd[2], 1'b1)
		xfer(1'b1, 8'h14, 32'h10);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(rd[4], 1'b0)
		xfer(1'b1, 8'h10, 32'h2);
		xfer(1'b1, 8'h08, 32'h15);
		inc_chk(32'h0003C65E);
		period_chk(17360, 17363);
		$display("running changes done");
	endtask
	task automatic t_limits();
		xfer(1'b1, 8'h00, 32'h32C8);
		rd_chk(8'h00, 32'h00002EE0);
		large_unit_pin <= 1'b1;
		xfer(1'b0, 8'h14, 32'h0);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(rd[3], 1'b1)
		xfer(1'b1, 8'h00, 32'h2328);
		rd_chk(8'h00, 32'h00001F40);
		xfer(1'b1, 8'h00, 32'h0);
		xfer(1'b1, 8'h08, 32'h1);
		inc_chk(32'h00064A9C);
		period_chk(10415, 10418);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(rd[0], 1'b1)
		xfer(1'b1, 8'h08, 32'h3);
		inc_chk(32'h00000000);
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(rd[0], 1'b0)
		$display("limits done");
	endtask
	initial begin
		mismatches = 0;
		samples_checked = 0;
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		speed_value = 16'h0;
		current_value = 16'h0;
		motor_running = 1'b0;
		large_unit_pin = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_speed();
		t_current();
		t_running();
		t_limits();
		tally_and_finish();
	end
endmodule
bind mpo_pulse_monitor mpo_pulse_monitor_checker i_mpo_pulse_monitor_checker (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.pulse_monitor_output, .monitor_common_return);
